// ==== common/ptc_pkg.sv ====
package ptc_pkg;

    // ------------------------------------------------------------
    // operations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_READ_TIMESTAMP  = 2'h0,
        OP_READ_EVENT_CTR  = 2'h1,
        OP_READ_MODEL_REG  = 2'h2,
        OP_WRITE_MODEL_REG = 2'h3
    } ptc_op_t;

    // ------------------------------------------------------------
    // widths and counts
    // ------------------------------------------------------------
    localparam int STAMP_W   = 64;
    localparam int REG_W     = 64;
    localparam int HALF_W    = 32;
    localparam int PROG_W    = 40;
    localparam int NUM_PROG  = 2;
    localparam int FIX_W     = 40;
    localparam int NUM_FIX   = 3;
    localparam int NUM_EVT   = 8;
    localparam int CPL_W     = 2;

    // ------------------------------------------------------------
    // model specific register offsets
    // ------------------------------------------------------------
    localparam logic [31:0] MR_STAMP     = 32'h0000_0010;
    localparam logic [31:0] MR_ID_LEAF   = 32'h0000_000A;
    localparam logic [31:0] MR_PMC_BASE  = 32'h0000_00C1;
    localparam logic [31:0] MR_SEL_BASE  = 32'h0000_0186;
    localparam logic [31:0] MR_FIX_BASE  = 32'h0000_0309;
    localparam logic [31:0] MR_FIX_CTL   = 32'h0000_038D;

    // ------------------------------------------------------------
    // event counter read index layout
    // ------------------------------------------------------------
    localparam int IDX_FIX_BIT = 30;

    // ------------------------------------------------------------
    // event select fields and reset value
    // ------------------------------------------------------------
    localparam int SEL_CODE_LSB = 0;
    localparam int SEL_CODE_W   = 8;
    localparam int SEL_DUR_BIT  = 8;
    localparam int SEL_EN_BIT   = 9;
    localparam int SEL_W        = 10;
    localparam logic [SEL_W-1:0] SEL_RST = 10'h000;

    // ------------------------------------------------------------
    // identification leaf fields
    // ------------------------------------------------------------
    localparam int ID_NPROG_LSB = 0;
    localparam int ID_PROGW_LSB = 8;
    localparam int ID_NFIX_LSB  = 16;
    localparam int ID_FIXW_LSB  = 24;

endpackage : ptc_pkg

// ==== common/ptc_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface ptc_if;
    import ptc_pkg::*;

    logic                reqValid;
    ptc_op_t             reqOp;
    logic [31:0]         reqIndex;
    logic [HALF_W-1:0]   reqHigh;
    logic [HALF_W-1:0]   reqLow;
    logic                reqWide;
    logic [CPL_W-1:0]    reqCpl;
    logic                rspValid;
    logic [REG_W-1:0]    rspHigh;
    logic [REG_W-1:0]    rspLow;
    logic                rspFault;

    modport dev (
        input  reqValid, reqOp, reqIndex, reqHigh, reqLow, reqWide, reqCpl,
        output rspValid, rspHigh, rspLow, rspFault
    );

    modport core (
        output reqValid, reqOp, reqIndex, reqHigh, reqLow, reqWide, reqCpl,
        input  rspValid, rspHigh, rspLow, rspFault
    );

endinterface : ptc_if

`default_nettype wire

// ==== verilog/ptc_counters.sv ====
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// (R1) 64-bit stamp counter cleared on reset
// (R2) stamp counts every clock it is not written, wraps to zero
// (R3) stamp read returns high and low halves
// (R4) upper result bits cleared in every mode
// (R5) two programmable, three fixed counters
// (R6) programmable counts occurrences or duration
// (R7) each programmable counter selects own event
// (R8) software writes event select via register write
// (R9) counter read returns count chosen by index
// (R10) wide mode index uses bits 30:0
// (R11) fixed counters count fixed events, reported
// (R12) model registers 64 bits, index selects
// (R13) read copies to halves, write loads halves
// (R14) model register index is 32 bits
// (R15) legacy: counters only via privileged read
// (R16) programmable counter wraps; write loads count
module ptc_counters (
    input  wire logic                     clk_sys,
    input  wire logic                     rst_n,
    ptc_if.dev                            bus,
    input  wire logic [ptc_pkg::NUM_EVT-1:0] evtIn,
    input  wire logic [ptc_pkg::NUM_FIX-1:0] fixedEvt,
    input  wire logic                     legacyMode
);
    import ptc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [STAMP_W-1:0] stampQ;
    logic [PROG_W-1:0]  pmcQ    [NUM_PROG];
    logic [SEL_W-1:0]   selQ    [NUM_PROG];
    logic               evtPrevQ[NUM_PROG];
    logic [FIX_W-1:0]   fixQ    [NUM_FIX];
    logic [NUM_FIX-1:0] fixEnQ;

    logic               rspValidQ;
    logic [REG_W-1:0]   rspHighQ;
    logic [REG_W-1:0]   rspLowQ;
    logic               rspFaultQ;

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    logic [REG_W-1:0] wrData;
    logic             wrReq;
    logic [31:0]      ctrIdx;
    logic [REG_W-1:0] readVal;
    logic             fault;
    logic [REG_W-1:0] idLeaf;

    assign wrData = {bus.reqHigh, bus.reqLow};                  // see (R13)
    assign wrReq  = bus.reqValid && bus.reqOp == OP_WRITE_MODEL_REG
                    && bus.reqCpl == '0;
    assign ctrIdx = bus.reqWide ? {1'b0, bus.reqIndex[30:0]}    // see (R10)
                                : bus.reqIndex;

    always_comb begin                                           // see (R11)
        idLeaf = '0;
        idLeaf[ID_NPROG_LSB +: 8] = 8'(NUM_PROG);
        idLeaf[ID_PROGW_LSB +: 8] = 8'(PROG_W);
        idLeaf[ID_NFIX_LSB +: 8]  = 8'(NUM_FIX);
        idLeaf[ID_FIXW_LSB +: 8]  = 8'(FIX_W);
    end

    always_comb begin
        readVal = '0;
        fault   = 1'b0;
        case (bus.reqOp)
            OP_READ_TIMESTAMP: begin
                readVal = stampQ;                               // see (R3)
            end
            OP_READ_EVENT_CTR: begin
                fault = 1'b1;
                if (!legacyMode) begin                          // see (R15)
                    for (int n = 0; n < NUM_PROG; n++) begin
                        if (ctrIdx == 32'(n)) begin             // see (R9)
                            readVal = REG_W'(pmcQ[n]);
                            fault   = 1'b0;
                        end
                    end
                    for (int n = 0; n < NUM_FIX; n++) begin
                        if (ctrIdx == (32'(n) | (32'h1 << IDX_FIX_BIT))) begin
                            readVal = REG_W'(fixQ[n]);
                            fault   = 1'b0;
                        end
                    end
                end
            end
            OP_READ_MODEL_REG, OP_WRITE_MODEL_REG: begin        // see (R12)
                fault = 1'b1;
                if (bus.reqIndex == MR_STAMP) begin             // see (R14)
                    readVal = stampQ;
                    fault   = 1'b0;
                end
                if (bus.reqIndex == MR_FIX_CTL) begin
                    readVal = REG_W'(fixEnQ);
                    fault   = 1'b0;
                end
                if (bus.reqIndex == MR_ID_LEAF) begin
                    readVal = idLeaf;
                    fault   = (bus.reqOp == OP_WRITE_MODEL_REG);
                end
                for (int n = 0; n < NUM_PROG; n++) begin
                    if (bus.reqIndex == MR_PMC_BASE + 32'(n)) begin
                        readVal = REG_W'(pmcQ[n]);
                        fault   = 1'b0;
                    end
                    if (bus.reqIndex == MR_SEL_BASE + 32'(n)) begin
                        readVal = REG_W'(selQ[n]);
                        fault   = 1'b0;
                    end
                end
                for (int n = 0; n < NUM_FIX; n++) begin
                    if (bus.reqIndex == MR_FIX_BASE + 32'(n)) begin
                        readVal = REG_W'(fixQ[n]);
                        fault   = 1'b0;
                    end
                end
                if (bus.reqCpl != '0) begin                     // see (R15)
                    fault = 1'b1;
                end
                if (bus.reqOp == OP_WRITE_MODEL_REG) begin
                    readVal = '0;
                end
            end
            default: begin
                fault = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // time-stamp counter
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stampQ <= '0;                                       // see (R1)
        end else if (wrReq && bus.reqIndex == MR_STAMP) begin
            stampQ <= wrData;
        end else begin
            stampQ <= stampQ + 1'b1;                            // see (R2)
        end
    end

    // ------------------------------------------------------------
    // programmable counters
    // ------------------------------------------------------------
    for (genvar g = 0; g < NUM_PROG; g++) begin : gProg       // see (R5)
        logic evtSel;
        logic [SEL_CODE_W-1:0] code;
        logic hit;

        assign code   = selQ[g][SEL_CODE_LSB +: SEL_CODE_W];
        assign evtSel = (32'(code) < NUM_EVT) ? evtIn[code[$clog2(NUM_EVT)-1:0]]
                                               : 1'b0;        // see (R7)
        assign hit    = selQ[g][SEL_DUR_BIT] ? evtSel          // see (R6)
                                             : (evtSel && !evtPrevQ[g]);

        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                selQ[g] <= SEL_RST;
            end else if (wrReq && bus.reqIndex == MR_SEL_BASE + 32'(g)) begin
                selQ[g] <= wrData[SEL_W-1:0];                   // see (R8)
            end
        end

        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                evtPrevQ[g] <= 1'b0;
            end else begin
                evtPrevQ[g] <= evtSel;
            end
        end

        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                pmcQ[g] <= '0;
            end else if (wrReq && bus.reqIndex == MR_PMC_BASE + 32'(g)) begin
                pmcQ[g] <= wrData[PROG_W-1:0];                  // see (R16)
            end else if (selQ[g][SEL_EN_BIT] && hit) begin
                pmcQ[g] <= pmcQ[g] + 1'b1;                      // see (R16)
            end
        end
    end

    // ------------------------------------------------------------
    // fixed-function counters
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fixEnQ <= '0;
        end else if (wrReq && bus.reqIndex == MR_FIX_CTL) begin
            fixEnQ <= wrData[NUM_FIX-1:0];
        end
    end

    for (genvar g = 0; g < NUM_FIX; g++) begin : gFix
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                fixQ[g] <= '0;
            end else if (wrReq && bus.reqIndex == MR_FIX_BASE + 32'(g)) begin
                fixQ[g] <= wrData[FIX_W-1:0];
            end else if (fixEnQ[g] && fixedEvt[g]) begin
                fixQ[g] <= fixQ[g] + 1'b1;                      // see (R11)
            end
        end
    end

    // ------------------------------------------------------------
    // response
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rspValidQ <= 1'b0;
            rspHighQ  <= '0;
            rspLowQ   <= '0;
            rspFaultQ <= 1'b0;
        end else begin
            rspValidQ <= bus.reqValid;
            if (bus.reqValid) begin
                rspHighQ  <= {32'h0, readVal[63:32]};           // see (R4)
                rspLowQ   <= {32'h0, readVal[31:0]};            // see (R13)
                rspFaultQ <= fault;
            end
        end
    end

    assign bus.rspValid = rspValidQ;
    assign bus.rspHigh  = rspHighQ;
    assign bus.rspLow   = rspLowQ;
    assign bus.rspFault = rspFaultQ;

endmodule : ptc_counters

`default_nettype wire

// ==== verilog/ptc_core_port.sv ====
`timescale 1ns/1ps
`default_nettype none

module ptc_core_port (
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    ptc_if.core                             bus,
    input  wire logic                       cmdValid,
    input  wire ptc_pkg::ptc_op_t           cmdOp,
    input  wire logic [31:0]                cmdIndex,
    input  wire logic [ptc_pkg::REG_W-1:0]  cmdData,
    input  wire logic                       cmdWide,
    input  wire logic [ptc_pkg::CPL_W-1:0]  cmdCpl,
    output var  logic                       cmdReady,
    output var  logic                       doneValid,
    output var  logic [ptc_pkg::REG_W-1:0]  doneData,
    output var  logic                       doneFault
);
    import ptc_pkg::*;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_WAIT = 1'b1
    } ptc_port_st_t;

    ptc_port_st_t       stateQ;
    logic               reqValidQ;
    ptc_op_t            reqOpQ;
    logic [31:0]        reqIndexQ;
    logic [HALF_W-1:0]  reqHighQ;
    logic [HALF_W-1:0]  reqLowQ;
    logic               reqWideQ;
    logic [CPL_W-1:0]   reqCplQ;

    // ------------------------------------------------------------
    // request issue
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stateQ    <= ST_IDLE;
            cmdReady  <= 1'b0;
            reqValidQ <= 1'b0;
            reqOpQ    <= OP_READ_TIMESTAMP;
            reqIndexQ <= '0;
            reqHighQ  <= '0;
            reqLowQ   <= '0;
            reqWideQ  <= 1'b0;
            reqCplQ   <= '0;
        end else begin
            reqValidQ <= 1'b0;
            case (stateQ)
                ST_IDLE: begin
                    cmdReady <= 1'b1;
                    if (cmdValid && cmdReady) begin
                        stateQ    <= ST_WAIT;
                        cmdReady  <= 1'b0;
                        reqValidQ <= 1'b1;
                        reqOpQ    <= cmdOp;
                        reqIndexQ <= (cmdWide && cmdOp == OP_READ_EVENT_CTR)
                                     ? {1'b0, cmdIndex[30:0]}   // see (R10)
                                     : cmdIndex;                // see (R14)
                        reqHighQ  <= cmdData[63:32];            // see (R8)
                        reqLowQ   <= cmdData[31:0];             // see (R12)
                        reqWideQ  <= cmdWide;
                        reqCplQ   <= cmdCpl;
                    end
                end
                ST_WAIT: begin
                    if (bus.rspValid) begin
                        stateQ   <= ST_IDLE;
                        cmdReady <= 1'b1;
                    end
                end
                default: begin
                    stateQ <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // answer capture
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            doneValid <= 1'b0;
            doneData  <= '0;
            doneFault <= 1'b0;
        end else begin
            doneValid <= bus.rspValid && stateQ == ST_WAIT;
            if (bus.rspValid && stateQ == ST_WAIT) begin
                doneData  <= {bus.rspHigh[31:0], bus.rspLow[31:0]};
                doneFault <= bus.rspFault;
            end
        end
    end

    assign bus.reqValid = reqValidQ;
    assign bus.reqOp    = reqOpQ;
    assign bus.reqIndex = reqIndexQ;
    assign bus.reqHigh  = reqHighQ;
    assign bus.reqLow   = reqLowQ;
    assign bus.reqWide  = reqWideQ;
    assign bus.reqCpl   = reqCplQ;

endmodule : ptc_core_port

`default_nettype wire

// ==== verification/ptc_sva.sv ====
`timescale 1ns/1ps
`default_nettype none

module ptc_sva (
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    input  wire logic                       reqValid,
    input  wire ptc_pkg::ptc_op_t           reqOp,
    input  wire logic [31:0]                reqIndex,
    input  wire logic [ptc_pkg::CPL_W-1:0]  reqCpl,
    input  wire logic                       rspValid,
    input  wire logic [ptc_pkg::REG_W-1:0]  rspHigh,
    input  wire logic [ptc_pkg::REG_W-1:0]  rspLow,
    input  wire logic                       rspFault
);
    import ptc_pkg::*;

    // ------------------------------------------------------------
    // stamp read history
    // ------------------------------------------------------------
    logic [63:0] lastStamp_q;
    logic [15:0] gap_q;
    logic        haveLast_q;
    logic        stampRead_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            stampRead_q <= 1'b0;
        else
            stampRead_q <= reqValid && reqOp == OP_READ_TIMESTAMP;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lastStamp_q <= 64'h0;
            gap_q       <= 16'h0;
            haveLast_q  <= 1'b0;
        end else if (reqValid && reqOp == OP_WRITE_MODEL_REG && reqIndex == MR_STAMP) begin
            haveLast_q  <= 1'b0;
        end else if (rspValid && stampRead_q) begin
            lastStamp_q <= {rspHigh[31:0], rspLow[31:0]};
            gap_q       <= 16'h1;
            haveLast_q  <= 1'b1;
        end else begin
            gap_q       <= gap_q + 16'h1;
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_rsp_after_req: assert property (
        reqValid |=> rspValid) else $error("no response one cycle after request");
    a_rsp_has_cause: assert property (
        rspValid |-> $past(reqValid)) else $error("response without request");
    a_upper_cleared: assert property (
        rspValid |-> (rspHigh[63:32] == 32'h0 && rspLow[63:32] == 32'h0))
        else $error("upper result bits not cleared");
    a_stamp_no_fault: assert property (
        reqValid && reqOp == OP_READ_TIMESTAMP |=> !rspFault) else $error("stamp read faulted");
    a_stamp_step: assert property (
        rspValid && stampRead_q && haveLast_q
        |-> {rspHigh[31:0], rspLow[31:0]} == lastStamp_q + gap_q)
        else $error("stamp did not advance once per clock");
    a_priv_fault: assert property (
        reqValid && (reqOp == OP_READ_MODEL_REG || reqOp == OP_WRITE_MODEL_REG)
        && reqCpl != 2'h0 |=> rspFault) else $error("unprivileged register access accepted");
    a_leaf_readonly: assert property (
        reqValid && reqOp == OP_WRITE_MODEL_REG && reqIndex == MR_ID_LEAF
        |=> rspFault) else $error("identification leaf write accepted");
    a_ctr_index: assert property (
        reqValid && reqOp == OP_READ_EVENT_CTR && !reqIndex[31]
        && !(reqIndex[30] ? reqIndex[29:0] < NUM_FIX : reqIndex[29:0] < NUM_PROG)
        |=> rspFault) else $error("bad counter index accepted");
    a_ctr_width: assert property (
        rspValid && !rspFault && $past(reqOp) == OP_READ_EVENT_CTR
        |-> rspHigh[31:PROG_W-HALF_W] == '0) else $error("counter wider than 40 bits");
    a_write_zero: assert property (
        rspValid && $past(reqOp) == OP_WRITE_MODEL_REG
        |-> rspHigh == 64'h0 && rspLow == 64'h0) else $error("write response data not zero");

endmodule : ptc_sva

`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import ptc_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    typedef struct packed {
        logic [REG_W-1:0] data;
        logic             fault;
        logic             chkData;
    } ptc_exp_t;

    localparam logic [REG_W-1:0] MASK40 = 64'h0000_00FF_FFFF_FFFF;

    logic               clk_sys    = 1'b0;
    logic               rst_n      = 1'b0;
    logic               cmdValid   = 1'b0;
    ptc_op_t            cmdOp      = OP_READ_TIMESTAMP;
    logic [31:0]        cmdIndex   = 32'h0;
    logic [REG_W-1:0]   cmdData    = 64'h0;
    logic               cmdWide    = 1'b0;
    logic [CPL_W-1:0]   cmdCpl     = 2'h0;
    logic [NUM_EVT-1:0] evtIn      = 8'h0;
    logic [NUM_FIX-1:0] fixedEvt   = 3'h0;
    logic               legacyMode = 1'b0;
    logic               cmdReady;
    logic               doneValid;
    logic [REG_W-1:0]   doneData;
    logic               doneFault;
    logic [63:0]        cyc;
    logic [63:0]        stampOff   = 64'h0;
    logic [63:0]        raw;
    logic [63:0]        ctrExp [5];
    integer             seed       = 32'hC12E;
    int                 num_errors = 0;
    int                 n_compared = 0;
    int                 ticks      = 0;
    int                 n;
    ptc_exp_t           expQ [$];
    ptc_exp_t           got;

    ptc_if link ();

    ptc_counters ptc_counters_inst (.clk_sys(clk_sys), .rst_n(rst_n), .bus(link),
        .evtIn(evtIn), .fixedEvt(fixedEvt), .legacyMode(legacyMode));

    ptc_core_port ptc_core_port_inst (.clk_sys(clk_sys), .rst_n(rst_n), .bus(link),
        .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdIndex(cmdIndex), .cmdData(cmdData),
        .cmdWide(cmdWide), .cmdCpl(cmdCpl), .cmdReady(cmdReady), .doneValid(doneValid),
        .doneData(doneData), .doneFault(doneFault));

    ptc_sva ptc_sva_inst (.clk_sys(clk_sys), .rst_n(rst_n), .reqValid(link.reqValid),
        .reqOp(link.reqOp), .reqIndex(link.reqIndex), .reqCpl(link.reqCpl),
        .rspValid(link.rspValid), .rspHigh(link.rspHigh), .rspLow(link.rspLow),
        .rspFault(link.rspFault));

    always #12.5 clk_sys = ~clk_sys;

    // bench copy of the stamp
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            cyc <= 64'h0;
        else
            cyc <= cyc + 64'h1;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    task automatic check(input string what, input logic [63:0] expV, input logic [63:0] gotV);
        n_compared++;
        if (gotV !== expV) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, expV, gotV);
        end
    endtask : check

    task automatic issue(input ptc_op_t op, input logic [31:0] idx, input logic [63:0] d,
                         input logic [63:0] ed, input logic ef, input logic w = 1'b0,
                         input logic [1:0] cpl = 2'h0, input logic stampRd = 1'b0);
        do @(posedge clk_sys); while (cmdReady !== 1'b1);
        if (stampRd)
            ed = cyc + 64'h2 + stampOff;
        if (op == OP_WRITE_MODEL_REG && idx == MR_STAMP && cpl == 2'h0)
            stampOff = d - cyc - 64'h3;
        expQ.push_back('{ed, ef, !ef || op == OP_WRITE_MODEL_REG});
        cmdValid <= 1'b1;
        cmdOp    <= op;
        cmdIndex <= idx;
        cmdData  <= d;
        cmdWide  <= w;
        cmdCpl   <= cpl;
        @(posedge clk_sys);
        cmdValid <= 1'b0;
    endtask : issue

    function automatic logic [31:0] ctrReg(input int i);
        return (i < NUM_PROG) ? MR_PMC_BASE + 32'(i) : MR_FIX_BASE + 32'(i - NUM_PROG);
    endfunction : ctrReg

    function automatic logic [31:0] ctrSel(input int i);
        return (i < NUM_PROG) ? 32'(i) : 32'h4000_0000 + 32'(i - NUM_PROG);
    endfunction : ctrSel

    // ------------------------------------------------------------
    // result monitor and watchdog
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (doneValid === 1'b1) begin
            if (expQ.size() == 0) begin
                check("unexpected result", 64'h0, 64'h1);
            end else begin
                got = expQ.pop_front();
                check("fault", 64'(got.fault), 64'(doneFault));
                if (got.chkData)
                    check("data", got.data, doneData);
            end
        end
    end

    always @(posedge clk_sys) begin
        ticks++;
        if (ticks == 4000) begin
            num_errors++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        issue(OP_READ_TIMESTAMP, 32'h0, 64'h0, 64'h0, 1'b0, 1'b0, 2'h0, 1'b1);
        issue(OP_READ_TIMESTAMP, 32'hFFFF_FFFF, 64'h0, 64'h0, 1'b0, 1'b1, 2'h0, 1'b1);
        issue(OP_READ_MODEL_REG, MR_STAMP, 64'h0, 64'h0, 1'b0, 1'b1, 2'h0, 1'b1);
        issue(OP_WRITE_MODEL_REG, MR_STAMP, 64'hFFFF_FFFF_FFFF_FFFE, 64'h0, 1'b0);
        issue(OP_READ_TIMESTAMP, 32'h0, 64'h0, 64'h0, 1'b0, 1'b0, 2'h0, 1'b1);
        issue(OP_READ_MODEL_REG, MR_ID_LEAF, 64'h0,
              64'({8'(FIX_W), 8'(NUM_FIX), 8'(PROG_W), 8'(NUM_PROG)}), 1'b0);
        issue(OP_WRITE_MODEL_REG, MR_ID_LEAF, 64'h1, 64'h0, 1'b1);
        issue(OP_READ_MODEL_REG, 32'h0000_0777, 64'h0, 64'h0, 1'b1);
        issue(OP_READ_MODEL_REG, MR_STAMP, 64'h0, 64'h0, 1'b1, 1'b0, 2'h1);
        for (int i = 0; i < 5; i++) begin
            raw = {$random(seed), $random(seed)};
            ctrExp[i] = raw & MASK40;
            issue(OP_WRITE_MODEL_REG, ctrReg(i), raw, 64'h0, 1'b0);
            issue(OP_READ_MODEL_REG, ctrReg(i), 64'h0, ctrExp[i], 1'b0);
            issue(OP_READ_EVENT_CTR, ctrSel(i) | 32'h8000_0000, 64'h0, ctrExp[i],
                  1'b0, 1'b1);
            if (i < NUM_PROG) begin
                issue(OP_WRITE_MODEL_REG, MR_SEL_BASE + 32'(i), raw, 64'h0, 1'b0);
                issue(OP_READ_MODEL_REG, MR_SEL_BASE + 32'(i), 64'h0, raw & 64'h3FF,
                      1'b0);
            end
        end
        issue(OP_READ_EVENT_CTR, 32'h2, 64'h0, 64'h0, 1'b1);
        issue(OP_READ_EVENT_CTR, 32'h4000_0003, 64'h0, 64'h0, 1'b1);
        legacyMode <= 1'b1;
        issue(OP_READ_EVENT_CTR, 32'h0, 64'h0, 64'h0, 1'b1);
        issue(OP_READ_MODEL_REG, MR_PMC_BASE, 64'h0, ctrExp[0], 1'b0);
        legacyMode <= 1'b0;
        // ctr 0 duration from max, ctr 1 edges
        issue(OP_WRITE_MODEL_REG, MR_PMC_BASE, MASK40, 64'h0, 1'b0);
        issue(OP_WRITE_MODEL_REG, MR_SEL_BASE, 64'h302, 64'h0, 1'b0);
        issue(OP_WRITE_MODEL_REG, MR_SEL_BASE + 32'h1, 64'h205, 64'h0, 1'b0);
        issue(OP_WRITE_MODEL_REG, MR_FIX_CTL, 64'h5, 64'h0, 1'b0);
        n = ($random(seed) & 7) + 1;
        repeat (3) @(posedge clk_sys);
        evtIn    <= 8'h2C;
        fixedEvt <= 3'h7;
        repeat (n) @(posedge clk_sys);
        evtIn    <= 8'h0;
        fixedEvt <= 3'h0;
        issue(OP_READ_EVENT_CTR, 32'h0, 64'h0, 64'(n - 1), 1'b0);
        issue(OP_READ_EVENT_CTR, 32'h1, 64'h0, (ctrExp[1] + 64'h1) & MASK40, 1'b0);
        for (int k = 0; k < NUM_FIX; k++)
            issue(OP_READ_EVENT_CTR, ctrSel(k + NUM_PROG), 64'h0,
                  (ctrExp[k + 2] + ((k == 1) ? 64'h0 : 64'(n))) & MASK40, 1'b0);
        // mid-run reset
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        stampOff = 64'h0;
        issue(OP_READ_TIMESTAMP, 32'h0, 64'h0, 64'h0, 1'b0, 1'b0, 2'h0, 1'b1);
        issue(OP_READ_EVENT_CTR, 32'h4000_0000, 64'h0, 64'h0, 1'b0);
        issue(OP_READ_MODEL_REG, MR_SEL_BASE, 64'h0, 64'h0, 1'b0);
        repeat (6) @(posedge clk_sys);
        check("pending results", 64'h0, 64'(expQ.size()));
        summarize();
    end

endmodule : tb_top

`default_nettype wire
